// file: health_regs.svh
`ifndef HEALTH_REGS_SVH
`define HEALTH_REGS_SVH
// ==========
// register offsets (byte addresses)
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_ERR_THRESH  12'h008
`define OFS_INTERVAL    12'h00C
`define OFS_PRED_THRESH 12'h010
`define OFS_TEMP_LIMIT  12'h014
`define OFS_TEMP_THREAT 12'h018
`define OFS_TEMP_NOW    12'h01C
`define OFS_DIAG_CMD    12'h020
`define OFS_LOG_INDEX   12'h028
`define OFS_LOG_DATA    12'h02C
`define OFS_LOG_LBA     12'h030
`define OFS_HISTORY     12'h034
// ==========
// control fields
`define CTRL_TEMP_WARN_EN   0
`define CTRL_METHOD_LSB     4
`define CTRL_METHOD_MSB     7
// diagnostic command fields (byte 1, bits 5..7)
`define DIAG_CODE_LSB       13
`define DIAG_CODE_MSB       15
// ==========
// reset values
`define RST_ERR_THRESH  16'h0010
`define RST_INTERVAL    16'h1000
`define RST_PRED_THRESH 8'h04
`define RST_TEMP_LIMIT  8'h3C
`define RST_TEMP_THREAT 8'h46
// ==========
// codes
`define WARN_CODE       16'h0801
`define NRDY_KEY        8'h02
`define NRDY_ASC        8'h04
`define NRDY_ASCQ_CAUSE 8'h00
`define NRDY_ASCQ_INIT  8'h03
`define RES_RUNNING     4'hF
`define RES_PASS        4'h0
`define RES_ABORT_APP   4'h1
`define RES_ABORT_RST   4'h2
`define LOG_DEPTH       20
// ==========
// timing
`define CLK_HZ          25000000
`define TEMP_PERIOD_S   600
`define SHORT_LIMIT_S   120
`endif

// file: health_pkg.sv
package health_pkg;
   typedef enum logic [2:0] {
      FN_NONE     = 3'b000,
      FN_SHORT    = 3'b001,
      FN_EXTENDED = 3'b010,
      FN_ABORT    = 3'b100
   } test_fn_t;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ELEC  = 3'b001,
      ST_SERVO = 3'b011,
      ST_SCAN  = 3'b010,
      ST_DONE  = 3'b110
   } test_state_t;
endpackage

// file: attr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "health_regs.svh"
// one monitored attribute: interval, failure and history counters
module attr_monitor
   import health_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // events
   input  wire logic        op_evt,
   input  wire logic        err_evt,
   // limits
   input  wire logic [15:0] interval_len,
   input  wire logic [15:0] err_thresh,
   input  wire logic [7:0]  pred_thresh,
   // state
   output logic [7:0]       history,
   output logic             pred_fail
);
   logic [15:0] op_cnt_ff;
   logic [15:0] err_cnt_ff;
   logic [7:0]  hist_ff;
   logic        pred_ff;
   logic [15:0] nxt_err;
   logic        over;
   logic        ends;

   // error count including this cycle's event
   assign nxt_err = err_cnt_ff + {15'h0000, err_evt};
   assign over    = nxt_err > err_thresh;
   assign ends    = op_evt && (op_cnt_ff + 16'h0001 >= interval_len);

   // interval and failure counters
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         op_cnt_ff  <= 16'h0000;
         err_cnt_ff <= 16'h0000;
      end else if (over || ends) begin
         op_cnt_ff  <= 16'h0000;
         err_cnt_ff <= 16'h0000;
      end else begin
         op_cnt_ff  <= op_cnt_ff + {15'h0000, op_evt};
         err_cnt_ff <= nxt_err;
      end
   end

   // failure history counter
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         hist_ff <= 8'h00;
      end else if (over) begin
         if (hist_ff != 8'hFF) begin
            hist_ff <= hist_ff + 8'h01;
         end
      end else if (ends && hist_ff != 8'h00) begin
         hist_ff <= hist_ff - 8'h01;
      end
   end

   // predictive failure flag
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pred_ff <= 1'b0;
      end else begin
         pred_ff <= (pred_thresh != 8'h00) && (hist_ff >= pred_thresh);
      end
   end

   assign history   = hist_ff;
   assign pred_fail = pred_ff;
endmodule
`default_nettype wire

// file: temp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "health_regs.svh"
// periodic temperature sampler with warning and frame save
module temp_monitor
   import health_pkg::*;
#(
   parameter longint unsigned PERIOD_CYC = 64'(`TEMP_PERIOD_S) * `CLK_HZ
)
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // sensor and limits
   input  wire logic [7:0] temp_sync,
   input  wire logic [7:0] temp_limit,
   input  wire logic [7:0] temp_threat,
   input  wire logic       warn_en,
   // results
   output logic [7:0]      temp_now,
   output logic            warn_pulse,
   output logic            save_pulse
);
   logic [33:0] tick_ff;
   logic [2:0]  first_ff;
   logic [7:0]  temp_ff;
   logic        warn_ff;
   logic        save_ff;
   logic        sample;

   assign sample = first_ff[2] || (tick_ff == 34'(PERIOD_CYC - 1));

   // sample timer, first sample once the pin synchroniser holds the pin
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tick_ff  <= 34'h0_0000_0000;
         first_ff <= 3'b001;
      end else begin
         first_ff <= {first_ff[1:0], 1'b0};
         tick_ff  <= sample ? 34'h0_0000_0000 : tick_ff + 34'h0_0000_0001;
      end
   end

   // sample and compare
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         temp_ff <= 8'h00;
         warn_ff <= 1'b0;
         save_ff <= 1'b0;
      end else begin
         warn_ff <= sample && warn_en && (temp_sync > temp_limit);
         save_ff <= sample && (temp_sync > temp_threat);
         if (sample) begin
            temp_ff <= temp_sync;
         end
      end
   end

   assign temp_now   = temp_ff;
   assign warn_pulse = warn_ff;
   assign save_pulse = save_ff;
endmodule
`default_nettype wire

// file: drive_health_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "health_regs.svh"
// Operation
// - count operations per attribute interval
// - count errors per attribute interval
// - errors over threshold mean unacceptable rate
// - judged interval clears both counters
// - history up on bad, down on good
// - history at threshold flags predictive failure
// - sample temperature at power-up, every ten minutes
// - over-limit sample reports warning 01-0801
// - warning needs enable, follows reporting method
// - threatening temperature saves monitoring frame
// - only unrecovered errors fail a self-test
// - recovered data never reports failure
// - not ready answers 02/04/00 or 02/04/03
// - function code byte 1 bits 5-7
// - tests run electrical, servo, scan segments
// - short test ends within 120 seconds
// - new entry at log front, 20 kept
// - entry gets code, result Fh, saved
// - result updated on completion or abort
// - failure records lba, sense, unit code
// - app abort gives 01, reset abort 02
module drive_health_monitor
   import health_pkg::*;
#(
   parameter int unsigned     SHORT_CYC  = unsigned'(`SHORT_LIMIT_S) * `CLK_HZ,
   parameter longint unsigned PERIOD_CYC = 64'(`TEMP_PERIOD_S) * `CLK_HZ
)
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // attribute events (same clock)
   input  wire logic [3:0]  op_evt,
   input  wire logic [3:0]  err_evt,
   // pins from drive mechanics
   input  wire logic [7:0]  temp_pin,
   input  wire logic        not_ready_pin,
   input  wire logic        cfg_unread_pin,
   input  wire logic        bus_reset_pin,
   // outcome of each test segment (same clock)
   // test_fault is an error left after all retries
   // test_fault_lba, sense, asc, ascq, unit qualify it
   input  wire logic        seg_done,
   input  wire logic        test_fault,
   input  wire logic [31:0] test_fault_lba,
   input  wire logic [7:0]  test_sense,
   input  wire logic [7:0]  test_asc,
   input  wire logic [7:0]  test_ascq,
   input  wire logic [7:0]  test_unit,
   // reports to host side
   output logic [3:0]       pred_fail,
   output logic             temp_warn,
   output logic [15:0]      warn_code,
   output logic [3:0]       warn_method,
   output logic             frame_save,
   output logic             log_store,
   output logic [2:0]       test_seg,
   output logic [7:0]       ready_key,
   output logic [7:0]       ready_asc,
   output logic [7:0]       ready_ascq
);
   // ==========
   // pin synchronisers
   logic [7:0] temp_s1_ff, temp_s2_ff;
   logic [2:0] pin_s1_ff,  pin_s2_ff;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         temp_s1_ff <= 8'h00;
         temp_s2_ff <= 8'h00;
         pin_s1_ff  <= 3'b000;
         pin_s2_ff  <= 3'b000;
      end else begin
         temp_s1_ff <= temp_pin;
         temp_s2_ff <= temp_s1_ff;
         pin_s1_ff  <= {bus_reset_pin, cfg_unread_pin, not_ready_pin};
         pin_s2_ff  <= pin_s1_ff;
      end
   end
   logic nrdy, cfgbad, busrst, busrst_d_ff;
   assign nrdy   = pin_s2_ff[0];
   assign cfgbad = pin_s2_ff[1];
   assign busrst = pin_s2_ff[2];

   // ==========
   // configuration registers
   logic        wr_en, rd_en;
   logic        warn_en_ff;
   logic [3:0]  method_ff;
   logic [15:0] err_thresh_ff, interval_ff;
   logic [7:0]  pred_thresh_ff, temp_limit_ff, temp_threat_ff;
   logic [4:0]  log_idx_ff;
   logic        diag_wr, dev_reset_wr;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign diag_wr      = wr_en && (paddr == `OFS_DIAG_CMD);
   assign dev_reset_wr = wr_en && (paddr == `OFS_CTRL) && pwdata[31];

   // software writes
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         warn_en_ff     <= 1'b0;
         method_ff      <= 4'h0;
         err_thresh_ff  <= `RST_ERR_THRESH;
         interval_ff    <= `RST_INTERVAL;
         pred_thresh_ff <= `RST_PRED_THRESH;
         temp_limit_ff  <= `RST_TEMP_LIMIT;
         temp_threat_ff <= `RST_TEMP_THREAT;
         log_idx_ff     <= 5'h00;
      end else if (wr_en) begin
         case (paddr)
            `OFS_CTRL: begin
               warn_en_ff <= pwdata[`CTRL_TEMP_WARN_EN];
               method_ff  <= pwdata[`CTRL_METHOD_MSB:`CTRL_METHOD_LSB];
            end
            `OFS_ERR_THRESH:  err_thresh_ff  <= pwdata[15:0];
            `OFS_INTERVAL:    interval_ff    <= pwdata[15:0];
            `OFS_PRED_THRESH: pred_thresh_ff <= pwdata[7:0];
            `OFS_TEMP_LIMIT:  temp_limit_ff  <= pwdata[7:0];
            `OFS_TEMP_THREAT: temp_threat_ff <= pwdata[7:0];
            `OFS_LOG_INDEX:   log_idx_ff     <= pwdata[4:0];
            default: ;
         endcase
      end
   end

   // ==========
   // attribute monitors
   logic [3:0] pred_w;
   logic [7:0] hist_w [4];
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_attr
         attr_monitor u_attr (
            .sys_clk      (sys_clk),
            .nrst         (nrst),
            .op_evt       (op_evt[g]),
            .err_evt      (err_evt[g]),
            .interval_len (interval_ff),
            .err_thresh   (err_thresh_ff),
            .pred_thresh  (pred_thresh_ff),
            .history      (hist_w[g]),
            .pred_fail    (pred_w[g])
         );
      end
   endgenerate

   // ==========
   // temperature monitor
   logic [7:0] temp_now_w;
   logic       warn_w, save_w;
   temp_monitor #(.PERIOD_CYC(PERIOD_CYC)) u_temp (
      .sys_clk     (sys_clk),
      .nrst        (nrst),
      .temp_sync   (temp_s2_ff),
      .temp_limit  (temp_limit_ff),
      .temp_threat (temp_threat_ff),
      .warn_en     (warn_en_ff),
      .temp_now    (temp_now_w),
      .warn_pulse  (warn_w),
      .save_pulse  (save_w)
   );

   // ==========
   // self-test sequencer
   test_state_t state_ff;
   test_fn_t    fn_ff;
   logic [31:0] elapse_ff;
   logic [3:0]  final_res;
   logic        start, app_abort, rst_abort, running, timeout;
   assign running   = (state_ff != ST_IDLE) && (state_ff != ST_DONE);
   // start only accepted when the drive is ready
   assign start     = diag_wr && !running && !nrdy && !cfgbad
                      && (pwdata[`DIAG_CODE_MSB:`DIAG_CODE_LSB] == FN_SHORT
                       || pwdata[`DIAG_CODE_MSB:`DIAG_CODE_LSB] == FN_EXTENDED);
   assign app_abort = diag_wr && running && (pwdata[`DIAG_CODE_MSB:`DIAG_CODE_LSB] == FN_ABORT);
   assign rst_abort = running && ((busrst && !busrst_d_ff) || dev_reset_wr);
   assign timeout   = running && (fn_ff == FN_SHORT) && (elapse_ff >= SHORT_CYC - 1);

   // segment walk
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff    <= ST_IDLE;
         fn_ff       <= FN_NONE;
         elapse_ff   <= 32'h0000_0000;
         busrst_d_ff <= 1'b0;
      end else begin
         busrst_d_ff <= busrst;
         elapse_ff   <= running ? elapse_ff + 32'h0000_0001 : 32'h0000_0000;
         if (start) begin
            state_ff  <= ST_ELEC;
            fn_ff     <= test_fn_t'(pwdata[`DIAG_CODE_MSB:`DIAG_CODE_LSB]);
         end else if (app_abort || rst_abort || timeout) begin
            state_ff <= ST_DONE;
         end else begin
            case (state_ff)
               ST_ELEC:  if (seg_done) state_ff <= test_fault ? ST_DONE : ST_SERVO;
               ST_SERVO: if (seg_done) state_ff <= test_fault ? ST_DONE : ST_SCAN;
               ST_SCAN:  if (seg_done) state_ff <= ST_DONE;
               ST_DONE:  state_ff <= ST_IDLE;
               ST_IDLE:  state_ff <= ST_IDLE;
               default:  state_ff <= ST_IDLE;
            endcase
         end
      end
   end

   // result code for the finishing test
   always_comb begin
      if (app_abort) begin
         final_res = `RES_ABORT_APP;
      end else if (rst_abort) begin
         final_res = `RES_ABORT_RST;
      end else if (running && seg_done && test_fault) begin
         final_res = {1'b0, state_ff};   // recovered errors never reach test_fault
      end else begin
         final_res = `RES_PASS;
      end
   end

   // ==========
   // results log, newest at index 0
   logic [3:0]  log_res_ff  [`LOG_DEPTH];
   logic [2:0]  log_fn_ff   [`LOG_DEPTH];
   logic [31:0] log_lba_ff  [`LOG_DEPTH];
   logic [31:0] log_sns_ff  [`LOG_DEPTH];
   logic        store_ff;
   logic        finish;
   assign finish = running && (app_abort || rst_abort || timeout
                   || (seg_done && (test_fault || state_ff == ST_SCAN)));
   generate
      for (g = 0; g < `LOG_DEPTH; g++) begin : g_log
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               log_res_ff[g] <= 4'h0;
               log_fn_ff[g]  <= 3'b000;
               log_lba_ff[g] <= 32'h0000_0000;
               log_sns_ff[g] <= 32'h0000_0000;
            end else if (start) begin
               // shift down, oldest drops off the end
               log_res_ff[g] <= (g == 0) ? `RES_RUNNING : log_res_ff[(g == 0) ? 0 : g - 1];
               log_fn_ff[g]  <= (g == 0) ? pwdata[`DIAG_CODE_MSB:`DIAG_CODE_LSB]
                                         : log_fn_ff[(g == 0) ? 0 : g - 1];
               log_lba_ff[g] <= (g == 0) ? 32'h0000_0000 : log_lba_ff[(g == 0) ? 0 : g - 1];
               log_sns_ff[g] <= (g == 0) ? 32'h0000_0000 : log_sns_ff[(g == 0) ? 0 : g - 1];
            end else if (finish && g == 0) begin
               log_res_ff[g] <= final_res;
               if (seg_done && test_fault) begin
                  log_lba_ff[g] <= test_fault_lba;
                  log_sns_ff[g] <= {test_sense, test_asc, test_ascq, test_unit};
               end
            end
         end
      end
   endgenerate

   // non-volatile store request on create and on update
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         store_ff <= 1'b0;
      end else begin
         store_ff <= start || finish;
      end
   end

   // ==========
   // reports and ready answer
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pred_fail   <= 4'h0;
         temp_warn   <= 1'b0;
         warn_code   <= 16'h0000;
         warn_method <= 4'h0;
         frame_save  <= 1'b0;
         ready_key   <= 8'h00;
         ready_asc   <= 8'h00;
         ready_ascq  <= 8'h00;
      end else begin
         pred_fail   <= pred_w;
         temp_warn   <= warn_w;
         frame_save  <= save_w;
         warn_method <= method_ff;
         if (warn_w) begin
            warn_code <= `WARN_CODE;
         end
         if (nrdy || cfgbad) begin
            ready_key  <= `NRDY_KEY;
            ready_asc  <= `NRDY_ASC;
            ready_ascq <= cfgbad ? `NRDY_ASCQ_INIT : `NRDY_ASCQ_CAUSE;
         end else begin
            ready_key  <= 8'h00;
            ready_asc  <= 8'h00;
            ready_ascq <= 8'h00;
         end
      end
   end
   assign log_store = store_ff;
   assign test_seg  = state_ff;

   // ==========
   // apb read, zero wait states
   logic [31:0] rdata;
   logic [4:0]  li;
   assign li = (log_idx_ff < 5'd20) ? log_idx_ff : 5'd0;
   always_comb begin
      case (paddr)
         `OFS_CTRL:        rdata = {24'h0000_00, method_ff, 3'b000, warn_en_ff};
         `OFS_STATUS:      rdata = {20'h0_0000, pred_w, 1'b0, state_ff, running, nrdy || cfgbad, 2'b00};
         `OFS_ERR_THRESH:  rdata = {16'h0000, err_thresh_ff};
         `OFS_INTERVAL:    rdata = {16'h0000, interval_ff};
         `OFS_PRED_THRESH: rdata = {24'h0000_00, pred_thresh_ff};
         `OFS_TEMP_LIMIT:  rdata = {24'h0000_00, temp_limit_ff};
         `OFS_TEMP_THREAT: rdata = {24'h0000_00, temp_threat_ff};
         `OFS_TEMP_NOW:    rdata = {24'h0000_00, temp_now_w};
         `OFS_DIAG_CMD:    rdata = {16'h0000, fn_ff, 13'h0000};
         `OFS_LOG_INDEX:   rdata = {27'h000_0000, log_idx_ff};
         `OFS_LOG_DATA:    rdata = {log_sns_ff[li][31:8], 1'b0, log_fn_ff[li], log_res_ff[li]};
         `OFS_LOG_LBA:     rdata = log_lba_ff[li];
         `OFS_HISTORY:     rdata = {hist_w[3], hist_w[2], hist_w[1], hist_w[0]};
         default:          rdata = 32'h0000_0000;
      endcase
   end

   // registered answer
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && (paddr > `OFS_HISTORY || paddr[1:0] != 2'b00);
         if (psel && !penable && !pwrite) begin
            prdata <= rdata;
         end
      end
   end
endmodule
`default_nettype wire

// file: drive_health_monitor_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker of the health block
module drive_health_monitor_monitor (
   // clock, reset, bus
   input wire logic       sys_clk,
   input wire logic       nrst,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   // pins and reports
   input wire logic       not_ready_pin,
   input wire logic       cfg_unread_pin,
   input wire logic       temp_warn,
   input wire logic       frame_save,
   input wire logic [2:0] test_seg,
   input wire logic [7:0] ready_key,
   input wire logic [7:0] ready_asc,
   input wire logic [7:0] ready_ascq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // bus answer and pulse widths
   property p_rdy; psel && !penable |=> pready; endproperty
   property p_pulse; pready |=> !pready; endproperty
   property p_tw; temp_warn |=> !temp_warn; endproperty
   property p_fs; frame_save |=> !frame_save; endproperty
   // not ready answers after pin sync
   property p_nrdy; (not_ready_pin && !cfg_unread_pin) [*5] |-> {ready_key, ready_asc, ready_ascq} == 24'h02_0400;
   endproperty
   property p_cfg; (cfg_unread_pin && !not_ready_pin) [*5] |-> {ready_key, ready_asc, ready_ascq} == 24'h02_0403;
   endproperty
   // segment order electrical, servo, scan
   property p_servo; test_seg == 3'd3 && $changed(test_seg) |-> $past(test_seg) == 3'd1; endproperty
   property p_scan; test_seg == 3'd2 && $changed(test_seg) |-> $past(test_seg) == 3'd3; endproperty
   a_rdy: assert property (p_rdy) else $error("ready late");
   a_pulse: assert property (p_pulse) else $error("ready too long");
   a_tw: assert property (p_tw) else $error("warn too long");
   a_fs: assert property (p_fs) else $error("save too long");
   a_nrdy: assert property (p_nrdy) else $error("not ready code");
   a_cfg: assert property (p_cfg) else $error("config code");
   a_servo: assert property (p_servo) else $error("servo order");
   a_scan: assert property (p_scan) else $error("scan order");
   c_warn: cover property (temp_warn);
   c_save: cover property (frame_save);
   c_scan: cover property (test_seg == 3'd2);
endmodule
bind drive_health_monitor drive_health_monitor_monitor chk (.*);
`default_nettype wire

// file: seg_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// drive mechanics: ends each test segment after lat cycles
module seg_model (
   // clock and reset
   input wire logic    sys_clk,
   input wire logic    nrst,
   // control
   input wire logic [7:0] lat,
   input wire logic [2:0] fail_seg,
   input wire logic [2:0] test_seg,
   // segment outcome
   output logic        seg_done,
   output logic        test_fault,
   output logic [31:0] lba,
   output logic [31:0] sinfo
);
   logic [7:0] cnt_ff;
   // count inside a running segment, restart per segment
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff   <= 8'h00;
         seg_done <= 1'b0;
      end else begin
         seg_done <= 1'b0;
         cnt_ff   <= cnt_ff + 8'h01;
         if (test_seg == 3'd0 || test_seg == 3'd6 || seg_done) cnt_ff <= 8'h00;
         else if (cnt_ff == lat) seg_done <= 1'b1;
      end
   end
   // fault only when retries are used up; otherwise inverted junk
   assign test_fault = seg_done && test_seg == fail_seg;
   assign lba = test_fault ? 32'h0000_1234 : 32'hFFFF_EDCB;
   assign sinfo = test_fault ? 32'h0311_0042 : 32'hFCEE_FFBD;
endmodule
`default_nettype wire

// file: drive_health_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "health_regs.svh"
// ==========
// bench: apb host plus mechanics model
module drive_health_monitor_tb;
   import health_pkg::*;
   logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
   logic not_ready_pin = 0, cfg_unread_pin = 0, bus_reset_pin = 0, seg_done, test_fault;
   logic temp_warn, frame_save, log_store;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, lba, sinfo;
   logic [3:0] op_evt = 0, err_evt = 0, pred_fail, warn_method;
   logic [7:0] temp_pin = 8'h20, lat = 8'd3, ready_key, ready_asc, ready_ascq;
   logic [2:0] fail_seg = 3'd7, test_seg;
   logic [15:0] warn_code;
   int n_fail = 0, cmp_count = 0, n_warn = 0, n_save = 0, n_store = 0;
   always #20 sys_clk = ~sys_clk;
   drive_health_monitor #(.SHORT_CYC(200), .PERIOD_CYC(100)) dut (.sys_clk, .nrst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .op_evt, .err_evt, .temp_pin, .not_ready_pin,
      .cfg_unread_pin, .bus_reset_pin, .seg_done, .test_fault, .test_fault_lba(lba),
      .test_sense(sinfo[31:24]), .test_asc(sinfo[23:16]), .test_ascq(sinfo[15:8]), .test_unit(sinfo[7:0]),
      .pred_fail, .temp_warn, .warn_code, .warn_method, .frame_save, .log_store, .test_seg,
      .ready_key, .ready_asc, .ready_ascq);
   seg_model mech (.sys_clk, .nrst, .lat, .fail_seg, .test_seg, .seg_done, .test_fault, .lba, .sinfo);
   // event tallies
   always @(posedge sys_clk) begin
      n_warn += temp_warn;
      n_save += frame_save;
      n_store += log_store;
   end
   task automatic end_of_test;
      if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tmo(input int k);
      if (k >= 2000) begin
         n_fail++;
         end_of_test();
      end
   endtask
   // one apb transfer, then one idle edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 2000);
      tmo(k);
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge sys_clk);
   endtask
   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(0, a, 0);
      chk(nm, rd & m, e);
   endtask
   // wait for the test to leave idle, or to end
   task automatic wait_seg(input logic idle);
      int k;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while ((idle ? (test_seg !== 3'd0 && test_seg !== 3'd6) : test_seg === 3'd0) && k < 2000);
      tmo(k);
   endtask
   task automatic start(input test_fn_t fn, input logic [2:0] fs);
      fail_seg <= fs;
      apb(1, `OFS_DIAG_CMD, {16'h0, fn, 13'h0});
      wait_seg(0);
   endtask
   task automatic fin(input logic [31:0] m, input logic [31:0] e);
      wait_seg(1);
      apb(1, `OFS_LOG_INDEX, 0);
      rdchk("log", `OFS_LOG_DATA, m, e);
   endtask
   // one interval of four operations with ne errors on em
   task automatic run_iv(input logic [3:0] em, input int ne);
      for (int j = 0; j < 4; j++) begin
         op_evt <= 4'hF;
         err_evt <= (j < ne) ? em : 4'h0;
         @(posedge sys_clk);
      end
      op_evt <= 0;
      err_evt <= 0;
      repeat (4) @(posedge sys_clk);
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      nrst <= 1;
      @(posedge sys_clk);
      rdchk("thr", `OFS_ERR_THRESH, 32'hFFFF, `RST_ERR_THRESH);
      rdchk("ivl", `OFS_INTERVAL, 32'hFFFF, `RST_INTERVAL);
      rdchk("pred", `OFS_PRED_THRESH, 32'hFF, `RST_PRED_THRESH);
      rdchk("lim", `OFS_TEMP_LIMIT, 32'hFF, `RST_TEMP_LIMIT);
      rdchk("threat", `OFS_TEMP_THREAT, 32'hFF, `RST_TEMP_THREAT);
      rdchk("unmapped", 12'h03C, 32'hFFFF_FFFF, 0);
      chk("slverr", se, 1);
      apb(1, `OFS_INTERVAL, 4);
      apb(1, `OFS_ERR_THRESH, 1);
      apb(1, `OFS_PRED_THRESH, 2);
      run_iv(4'h3, 2);
      run_iv(4'h3, 2);
      chk("pred_fail", pred_fail, 4'h3);
      run_iv(4'h2, 1);
      chk("pred_fail", pred_fail, 4'h0);
      apb(1, `OFS_CTRL, 32'h31);
      temp_pin <= 8'h40;
      repeat (130) @(posedge sys_clk);
      chk("warn", n_warn > 0 && n_save == 0, 1);
      chk("code", warn_code, `WARN_CODE);
      chk("method", warn_method, 4'h3);
      apb(1, `OFS_CTRL, 0);
      temp_pin <= 8'h50;
      n_warn = 0;
      repeat (130) @(posedge sys_clk);
      chk("nowarn", n_warn == 0 && n_save > 0, 1);
      not_ready_pin <= 1;
      repeat (6) @(posedge sys_clk);
      chk("nrdy", {ready_key, ready_asc, ready_ascq}, 24'h02_0400);
      apb(1, `OFS_DIAG_CMD, 32'h2000);
      repeat (5) @(posedge sys_clk);
      chk("refuse", test_seg, 0);
      not_ready_pin <= 0;
      cfg_unread_pin <= 1;
      repeat (6) @(posedge sys_clk);
      chk("cfg", {ready_key, ready_asc, ready_ascq}, 24'h02_0403);
      cfg_unread_pin <= 0;
      repeat (6) @(posedge sys_clk);
      start(FN_SHORT, 7);
      fin(32'h7F, 32'h10);
      start(FN_EXTENDED, 3);
      fin(32'hFFFF_FF7F, 32'h0311_0023);
      rdchk("lba", `OFS_LOG_LBA, 32'hFFFF_FFFF, 32'h1234);
      apb(1, `OFS_LOG_INDEX, 1);
      rdchk("older", `OFS_LOG_DATA, 32'h7F, 32'h10);
      lat <= 8'd40;
      start(FN_EXTENDED, 7);
      apb(1, `OFS_LOG_INDEX, 0);
      rdchk("running", `OFS_LOG_DATA, 32'h7F, 32'h2F);
      apb(1, `OFS_DIAG_CMD, {16'h0, FN_ABORT, 13'h0});
      fin(32'h7F, 32'h21);
      start(FN_SHORT, 7);
      bus_reset_pin <= 1;
      repeat (4) @(posedge sys_clk);
      bus_reset_pin <= 0;
      fin(32'h7F, 32'h12);
      lat <= 8'd250;
      start(FN_SHORT, 1);
      fin(32'h7F, 32'h10);
      chk("stores", n_store, 10);
      end_of_test();
   end
endmodule
`default_nettype wire
